// File: core/cam_map.svh
/*
 acceptance mask register map: offsets, field positions, reset values.
 assumes inclusion by bare name from the mask block sources.
*/
`ifndef CAM_MAP_SVH
`define CAM_MAP_SVH
`define CAM_NUM_SETS 3
`define CAM_SET_STRIDE 32'h0000_0008
`define CAM_OFS_STD 32'h0000_0000
`define CAM_OFS_EXT 32'h0000_0004
`define CAM_ADDR_BITS 5
`define CAM_STD_HI 15
`define CAM_STD_LO 5
`define CAM_TYPE_BIT 3
`define CAM_EXT_HI_HI 1
`define CAM_EXT_HI_LO 0
`define CAM_STD_WMASK 16'hffeb
`define CAM_RESP_OKAY 2'b00
`define CAM_RESP_SLVERR 2'b10
`define CAM_MASK_RESET 16'h0000
`endif

// File: core/cam_pkg.sv
/*
 types shared by the acceptance mask block.
 assumes cam_map.svh is compiled with it.
*/
`default_nettype none
package cam_pkg;
	typedef struct packed {
		logic [15:0] std_reg;
		logic [15:0] ext_reg;
	} cam_set_t;
	typedef struct packed {
		logic [10:0] std_id;
		logic [17:0] ext_id;
		logic is_ext;
	} cam_ident_t;
	typedef enum logic [1:0] {CAM_W_IDLE, CAM_W_RESP} cam_wstate_t;
endpackage : cam_pkg
`default_nettype wire

// File: core/cam_match.sv
/*
 identifier compare against one mask set and one filter.
 assumes identifier and filter inputs are stable in the clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cam_map.svh"
module cam_match (
	input wire cam_pkg::cam_set_t mask,
	input wire cam_pkg::cam_ident_t ident,
	input wire cam_pkg::cam_ident_t filt,
	output logic hit
);
	logic [10:0] std_m;
	logic [17:0] ext_m;
	logic std_ok;
	logic ext_ok;
	logic type_ok;
	always_comb
	begin
		std_m = mask.std_reg[`CAM_STD_HI:`CAM_STD_LO];
		ext_m = {mask.std_reg[`CAM_EXT_HI_HI:`CAM_EXT_HI_LO], mask.ext_reg};
		std_ok = ((ident.std_id ^ filt.std_id) & std_m) == 11'h000;
		// standard frames carry no extended bits, so those only count for extended frames
		ext_ok = !ident.is_ext || (((ident.ext_id ^ filt.ext_id) & ext_m) == 18'h00000);
		type_ok = !mask.std_reg[`CAM_TYPE_BIT] || (ident.is_ext == filt.is_ext);
		hit = std_ok && ext_ok && type_ok;
	end
endmodule : cam_match
`default_nettype wire

// File: core/cam_regs.sv
/*
 acceptance mask registers with AXI4-Lite slave and one registered match output for the set chosen by filt_mask_sel.
 assumes one clock aclk and synchronous active-low reset aresetn.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cam_map.svh"
module cam_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`CAM_ADDR_BITS-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`CAM_ADDR_BITS-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire cam_pkg::cam_ident_t rx_ident,
	input wire cam_pkg::cam_ident_t filt_ident,
	input wire logic [1:0] filt_mask_sel,
	output logic match_r
);
	////////////////////////////////////////////////////////////////////////
	cam_pkg::cam_set_t sets_r [`CAM_NUM_SETS];
	cam_pkg::cam_set_t sets_nxt [`CAM_NUM_SETS];
	logic aw_held_r;
	logic aw_held_nxt;
	logic w_held_r;
	logic w_held_nxt;
	logic awready_r;
	logic awready_nxt;
	logic wready_r;
	logic wready_nxt;
	logic [`CAM_ADDR_BITS-1:0] awaddr_r;
	logic [`CAM_ADDR_BITS-1:0] awaddr_nxt;
	logic [31:0] wdata_r;
	logic [31:0] wdata_nxt;
	logic [3:0] wstrb_r;
	logic [3:0] wstrb_nxt;
	logic bvalid_r;
	logic bvalid_nxt;
	logic [1:0] bresp_r;
	logic [1:0] bresp_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	logic arready_r;
	logic arready_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [1:0] rresp_r;
	logic [1:0] rresp_nxt;
	logic match_nxt;
	wire logic [`CAM_NUM_SETS-1:0] hits;

	// byte address to set index and register kind; false for holes and unaligned words
	function automatic logic decode(input logic [`CAM_ADDR_BITS-1:0] a,
		output logic [1:0] set, output logic is_ext);
		logic [31:0] off;
		off = 32'(a);
		set = 2'(off / `CAM_SET_STRIDE);
		is_ext = (off % `CAM_SET_STRIDE) == `CAM_OFS_EXT;
		return (is_ext || (off % `CAM_SET_STRIDE) == `CAM_OFS_STD)
			&& (off / `CAM_SET_STRIDE < 32'(`CAM_NUM_SETS));
	endfunction : decode

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
		input logic [3:0] strb);
		return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
	endfunction : merge

	////////////////////////////////////////////////////////////////////////
	// write path: address and data slots fill in either order, then commit together
	always_comb
	begin
		logic [1:0] wset;
		logic wext;
		logic wok;
		wset = 2'b00;
		wext = 1'b0;
		wok = 1'b0;
		sets_nxt = sets_r;
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (s_axi_awvalid && awready_r)
		begin
			aw_held_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r)
		begin
			w_held_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
		wok = decode(awaddr_r, wset, wext);
		// a pending response blocks the commit, so one write is under way at a time
		if (aw_held_r && w_held_r && !bvalid_r)
		begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wok ? `CAM_RESP_OKAY : `CAM_RESP_SLVERR;
			if (wok && wext)
				sets_nxt[wset].ext_reg = merge(sets_r[wset].ext_reg, wdata_r[15:0], wstrb_r);
			else if (wok)
				sets_nxt[wset].std_reg = merge(sets_r[wset].std_reg, wdata_r[15:0], wstrb_r)
					& `CAM_STD_WMASK;
		end
		// ready is kept in its own flop so the port needs no gate after the register
		awready_nxt = !aw_held_nxt;
		wready_nxt = !w_held_nxt;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			// mask contents are undefined after reset; zeroed here for determinism
			for (int i = 0; i < `CAM_NUM_SETS; i++)
				sets_r[i] <= '{std_reg: `CAM_MASK_RESET, ext_reg: `CAM_MASK_RESET};
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			awaddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `CAM_RESP_OKAY;
		end
		else
		begin
			sets_r <= sets_nxt;
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path: one read at a time, answered on the same edge that takes it
	always_comb
	begin
		logic [1:0] rset;
		logic rext;
		logic rok;
		rset = 2'b00;
		rext = 1'b0;
		rok = decode(s_axi_araddr, rset, rext);
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
		if (s_axi_arvalid && arready_r)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = rok ? `CAM_RESP_OKAY : `CAM_RESP_SLVERR;
			rdata_nxt = 32'h0000_0000;
			if (rok)
				rdata_nxt[15:0] = rext ? sets_r[rset].ext_reg : sets_r[rset].std_reg;
		end
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `CAM_RESP_OKAY;
		end
		else
		begin
			rvalid_r <= rvalid_nxt;
			arready_r <= arready_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// match result is registered: it follows identifier, filter or mask by one edge
	always_comb
	begin
		logic [3:0] hit_sel;
		hit_sel = 4'(hits);
		// index 3 selects no set and reads the zero pad, so it never matches
		match_nxt = (filt_mask_sel < 2'(`CAM_NUM_SETS)) && hit_sel[filt_mask_sel];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			match_r <= 1'b0;
		else
			match_r <= match_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_arready = arready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	for (genvar g = 0; g < `CAM_NUM_SETS; g++)
	begin : g_set
		cam_match u_match (
			.mask(sets_r[g]),
			.ident(rx_ident),
			.filt(filt_ident),
			.hit(hits[g])
		);
	end
endmodule : cam_regs
`default_nettype wire

// File: verification/cam_regs_asserts.sv
/* port assertions for cam_regs
 bound to every cam_regs instance */
`timescale 1ns/10ps
`default_nettype none
module cam_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire cam_pkg::cam_ident_t rx_ident,
	input wire cam_pkg::cam_ident_t filt_ident,
	input wire logic [1:0] filt_mask_sel,
	input wire logic match_r
);
logic [4:0] ra_r;
always_ff @(posedge aclk)
	if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
read_late_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("read not answered");
read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
	else $error("read data dropped");
ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
	else $error("read taken while busy");
resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
	else $error("write response dropped");
unused_zero_a: assert property (s_axi_rvalid && ra_r[2:0] == 3'h0 |-> !s_axi_rdata[4] && !s_axi_rdata[2])
	else $error("unused bits read set");
upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
	else $error("upper half read set");
no_set3_a: assert property (filt_mask_sel == 2'h3 |=> !match_r)
	else $error("fourth set matched");
equal_hit_a: assert property (rx_ident == filt_ident && filt_mask_sel != 2'h3 |=> match_r)
	else $error("equal identifier missed");
endmodule : cam_chk
bind cam_regs cam_chk cam_chk_inst (.*);
`default_nettype wire

// File: verification/cam_node.sv
/* other bus nodes: a new received identifier on each request
 assumes nxt is driven just after a clock edge */
`timescale 1ns/10ps
`default_nettype none
module cam_node (
	input wire logic clk,
	input wire logic nxt,
	output var cam_pkg::cam_ident_t frame = '0
);
// standard frames still carry random extended bits: no kinder than a noisy field
always @(posedge clk)
	if (nxt) frame <= 30'($urandom);
endmodule : cam_node
`default_nettype wire

// File: verification/can_acceptance_mask_regs_test.sv
/* self-checking bench for cam_regs
 assumes the cam_node partner and the bound checker */
`timescale 1ns/10ps
`default_nettype none
module can_acceptance_mask_regs_test;
logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, nxt = 0;
logic s_axi_arvalid = 0, s_axi_rready = 0;
logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
logic [31:0] s_axi_wdata = '0;
logic [3:0] s_axi_wstrb = 4'hf;
logic [1:0] filt_mask_sel = '0;
cam_pkg::cam_ident_t rx_ident, filt_ident = '0, f;
wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, match_r;
wire logic [1:0] s_axi_bresp, s_axi_rresp;
wire logic [31:0] s_axi_rdata;
int fail_count = 0, cmp_count = 0, cyc = 0, m [6];
cam_regs cam_regs_inst (.*);
cam_node cam_node_inst (.clk(aclk), .nxt(nxt), .frame(rx_ident));
always #5 aclk = ~aclk;
task chk(input string n, input logic [31:0] e, s);
	cmp_count++;
	if (e !== s)
	begin
		fail_count++;
		$display("MISMATCH %s exp %h got %h", n, e, s);
	end
endtask : chk
function automatic bit ok(input logic [4:0] a);
	return a[1:0] == 2'h0 && a[4:2] < 3'h6;
endfunction : ok
task wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
	logic [15:0] v;
	@(posedge aclk);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_wstrb <= s;
	s_axi_awvalid <= 1;
	s_axi_wvalid <= 1;
	s_axi_bready <= 1;
	do
	begin
		@(posedge aclk);
		if (s_axi_awready) s_axi_awvalid <= 0;
		if (s_axi_wready) s_axi_wvalid <= 0;
	end
	while (!s_axi_bvalid);
	s_axi_bready <= 0;
	chk("bresp", ok(a) ? 0 : 2, s_axi_bresp);
	// only byte lanes 0 and 1 reach a register; the standard word drops bits 4 and 2
	if (ok(a))
	begin
		v = 16'(m[a[4:2]]);
		if (s[1]) v[15:8] = d[15:8];
		if (s[0]) v[7:0] = d[7:0];
		m[a[4:2]] = a[2] ? v : v & 16'hffeb;
	end
endtask : wr
task rd(input logic [4:0] a);
	@(posedge aclk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1;
	s_axi_rready <= 1;
	do
	begin
		@(posedge aclk);
		if (s_axi_arready) s_axi_arvalid <= 0;
	end
	while (!s_axi_rvalid);
	s_axi_rready <= 0;
	chk("rdata", ok(a) ? m[a[4:2]] : 0, s_axi_rdata);
	chk("rresp", ok(a) ? 0 : 2, s_axi_rresp);
endtask : rd
function automatic bit hit(input int s, input cam_pkg::cam_ident_t r, q);
	logic [31:0] k;
	logic [31:0] e;
	if (s == 3) return 0;
	k = m[2 * s];
	e = m[2 * s + 1];
	if (k[3] && r.is_ext != q.is_ext) return 0;
	if (((r.std_id ^ q.std_id) & k[15:5]) != 0) return 0;
	return !r.is_ext || ((r.ext_id ^ q.ext_id) & {k[1:0], e[15:0]}) == 0;
endfunction : hit
task summarize;
	$display("compares %0d mismatches %0d", cmp_count, fail_count);
	if (fail_count == 0 && cmp_count > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask : summarize
always @(posedge aclk)
begin
	cyc++;
	if (cyc == 20000)
	begin
		fail_count++;
		summarize();
	end
end
initial
begin
	void'($urandom(32'hff801cf3));
	repeat (6) @(posedge aclk);
	aresetn <= 1;
	for (int i = 0; i < 9; i++) wr(i < 8 ? 5'(i * 4) : 5'h05, $urandom, 4'hf);
	for (int i = 0; i < 9; i++) rd(i < 8 ? 5'(i * 4) : 5'h05);
	$display("register test done");
	// a reset in mid-run brings every mask back to the zero chosen for reset
	@(posedge aclk);
	aresetn <= 0;
	repeat (2) @(posedge aclk);
	aresetn <= 1;
	for (int i = 0; i < 6; i++) m[i] = 0;
	for (int i = 0; i < 6; i++) rd(5'(i * 4));
	$display("reset test done");
	for (int i = 0; i < 300; i++)
	begin
		if (i % 8 == 0) wr(5'($urandom % 6 * 4), $urandom & $urandom, 4'($urandom));
		@(posedge aclk);
		nxt <= 1;
		filt_mask_sel <= 2'($urandom);
		@(posedge aclk);
		nxt <= 0;
		@(negedge aclk);
		f = rx_ident ^ 30'($urandom & $urandom & $urandom);
		@(posedge aclk);
		filt_ident <= f;
		repeat (2) @(negedge aclk);
		chk("match", hit(filt_mask_sel, rx_ident, f), match_r);
	end
	$display("match test done");
	summarize();
end
endmodule : can_acceptance_mask_regs_test
`default_nettype wire
